//--- hdl/lane_test_map.vh
// Constants for the lane test sequencer and checker
`ifndef LANE_TEST_MAP_VH
`define LANE_TEST_MAP_VH

`define LT_LANES 2
`define LT_K_COMMA 8'hbc
`define LT_K_START 8'h1c
`define LT_K_END 8'h7c
`define LT_CHECK_BYTE 8'hbc
`define LT_COMMA_WORDS 8'h40
`define LT_FRAMES 3'h4
`define LT_FRAME_BYTES 8'h20
`define LT_CFG_BYTES 8'h0e
`define LT_CFG_POS 8'h01
`define LT_CFG_FILL 8'hbc
`define LT_WORD_BYTES 8'h04
`define LT_START_POS 8'h00
`define LT_RUN_CYCLES 32'h00001000
`define LT_TIMEOUT_CYCLES 32'h00010000

`endif

//--- hdl/lane_checker.v
// Per-lane receive byte checker with sticky error flag
`timescale 1ns/1ps
`default_nettype none
`include "lane_test_map.vh"

module lane_checker (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Lane input
	input wire [31:0] rx_data,
	input wire [3:0] rx_is_k,
	input wire check_en,
	// Result
	output reg error
);
	wire [3:0] bad;
	genvar s;

	// RULE8: compare data bytes
	generate
		for (s = 0; s < 4; s = s + 1) begin : g_byte
			assign bad[s] = !rx_is_k[s] && (rx_data[s*8 +: 8] != `LT_CHECK_BYTE);
		end
	endgenerate

	// RULE9: sticky until reset
	always @(posedge clk) begin
		if (!reset_n) begin
			error <= 1'b0;
		end else if (check_en && |bad) begin
			error <= 1'b1;
		end
	end
endmodule

`default_nettype wire

//--- hdl/lane_test_sequencer.v
// Lane test pattern sequencer with loopback select and run control
`timescale 1ns/1ps
`default_nettype none
`include "lane_test_map.vh"

// What this block does
// RULE1: Once both channels leave reset, every lane sends a run of K28.5 commas.
// RULE2: After the commas, four frames follow, each opened by a start and closed by an end character.
// RULE3: The configuration marker and its 14 bytes are not sent; their positions carry 8'hbc filler instead.
// RULE4: The alignment frames hold only K28.0, K28.3 and data bytes, letting the receiver find 32-bit words.
// RULE5: An enable tells the receive checker when incoming data is valid, and checking waits for it.
// RULE6: With equal line rates chosen at build time, transmitted lanes loop back to the receive inputs.
// RULE7: After alignment the run streams for a set count of cycles, and a timeout ends a stalled run.
// RULE8: The checker compares each received data byte against 8'hbc once enabled.
// RULE9: Each lane keeps a sticky error flag on mismatch, cleared only by reset.
module lane_test_sequencer #(
	parameter LOOPBACK = 1,
	parameter [31:0] RUN_CYCLES = `LT_RUN_CYCLES,
	parameter [31:0] TIMEOUT_CYCLES = `LT_TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Channel reset done
	input wire tx_reset_done,
	input wire rx_reset_done,
	// Transmit lanes
	output reg [`LT_LANES*32-1:0] tx_data,
	output reg [`LT_LANES*4-1:0] tx_is_k,
	// Receive lanes from transceivers
	input wire [`LT_LANES*32-1:0] rx_data_in,
	input wire [`LT_LANES*4-1:0] rx_is_k_in,
	// Status
	output wire check_en,
	output wire [`LT_LANES-1:0] lane_error,
	output reg done,
	output reg timed_out
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_COMMA = 3'h1;
	localparam [2:0] ST_FRAME = 3'h2;
	localparam [2:0] ST_STREAM = 3'h3;
	localparam [2:0] ST_DONE = 3'h4;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [7:0] word_cnt;
	reg [7:0] byte_pos;
	reg [2:0] frame_cnt;
	reg [31:0] run_cnt;
	reg [31:0] tmo_cnt;
	reg [31:0] word;
	reg [3:0] word_k;
	wire [31:0] frame_word;
	wire [3:0] frame_k;

	// Both channels up; a drop before the run is done restarts the sequence
	wire chans_up = tx_reset_done && rx_reset_done;
	// Last word of a frame once this word is counted
	wire frame_last = (byte_pos + `LT_WORD_BYTES) >= `LT_FRAME_BYTES;
	wire [`LT_LANES*32-1:0] rx_data;
	wire [`LT_LANES*4-1:0] rx_is_k;

	// RULE6: build-time loopback
	generate
		if (LOOPBACK != 0) begin : g_loop
			assign rx_data = tx_data;
			assign rx_is_k = tx_is_k;
		end else begin : g_ext
			assign rx_data = rx_data_in;
			assign rx_is_k = rx_is_k_in;
		end
	endgenerate

	// RULE5: checking enabled after alignment
	assign check_en = (state == ST_STREAM);

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: if (chans_up) next_state = ST_COMMA;
			ST_COMMA: if (word_cnt == `LT_COMMA_WORDS - 8'h01) next_state = ST_FRAME;
			ST_FRAME: if (frame_last && frame_cnt == `LT_FRAMES - 3'h1) next_state = ST_STREAM;
			ST_STREAM: if (run_cnt == RUN_CYCLES - 32'h1) next_state = ST_DONE;
			ST_DONE: next_state = ST_DONE;
			default: next_state = ST_IDLE;
		endcase
		// A finished run keeps its result until reset
		if (!chans_up && state != ST_DONE)
			next_state = ST_IDLE;
		if (timed_out)
			next_state = ST_DONE;
	end

	// Frame bytes, one slot per byte of the word
	genvar s;
	generate
		for (s = 0; s < 4; s = s + 1) begin : g_slot
			localparam [7:0] SLOT = s;
			wire [7:0] pos;
			wire is_start;
			wire is_end;
			wire in_cfg;
			assign pos = byte_pos + SLOT;
			// RULE4: start and end characters
			assign is_start = (pos == `LT_START_POS);
			assign is_end = (pos == `LT_FRAME_BYTES - 8'h01);
			// RULE3: skipped configuration positions
			assign in_cfg = (pos >= `LT_CFG_POS) && (pos <= `LT_CFG_POS + `LT_CFG_BYTES);
			assign frame_k[s] = is_start || is_end;
			assign frame_word[s*8 +: 8] = is_start ? `LT_K_START :
				is_end ? `LT_K_END :
				in_cfg ? `LT_CFG_FILL : `LT_CHECK_BYTE;
		end
	endgenerate

	// Build one 32-bit word of the current state
	always @* begin
		word = {4{`LT_CHECK_BYTE}};
		word_k = 4'h0;
		case (state)
			// RULE1: comma run on all lanes
			ST_COMMA: begin
				word = {4{`LT_K_COMMA}};
				word_k = 4'hf;
			end
			ST_FRAME: begin
				word = frame_word;
				word_k = frame_k;
			end
			default: begin
				word = {4{`LT_CHECK_BYTE}};
				word_k = 4'h0;
			end
		endcase
	end

	// State and transmit word registers
	always @(posedge clk) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			tx_data <= {`LT_LANES*32{1'b0}};
			tx_is_k <= {`LT_LANES*4{1'b0}};
		end else begin
			state <= next_state;
			tx_data <= {`LT_LANES{word}};
			tx_is_k <= {`LT_LANES{word_k}};
		end
	end

	// Comma words sent so far
	always @(posedge clk) begin
		if (!reset_n)
			word_cnt <= 8'h00;
		else if (state == ST_COMMA)
			word_cnt <= word_cnt + 8'h01;
		else
			word_cnt <= 8'h00;
	end

	// RULE2: four framed sequences
	always @(posedge clk) begin
		if (!reset_n) begin
			byte_pos <= 8'h00;
			frame_cnt <= 3'h0;
		end else if (state == ST_FRAME) begin
			byte_pos <= frame_last ? 8'h00 : byte_pos + `LT_WORD_BYTES;
			if (frame_last)
				frame_cnt <= frame_cnt + 3'h1;
		end else begin
			byte_pos <= 8'h00;
			frame_cnt <= 3'h0;
		end
	end

	// RULE7: stream run length
	always @(posedge clk) begin
		if (!reset_n)
			run_cnt <= 32'h0;
		else if (state == ST_STREAM)
			run_cnt <= run_cnt + 32'h1;
		else
			run_cnt <= 32'h0;
	end

	// RULE7: stall timeout, counted until streaming starts
	always @(posedge clk) begin
		if (!reset_n) begin
			tmo_cnt <= 32'h0;
			timed_out <= 1'b0;
		end else if (state != ST_STREAM && state != ST_DONE) begin
			if (tmo_cnt == TIMEOUT_CYCLES - 32'h1)
				timed_out <= 1'b1;
			else
				tmo_cnt <= tmo_cnt + 32'h1;
		end
	end

	// End of run, held until reset
	always @(posedge clk) begin
		if (!reset_n)
			done <= 1'b0;
		else if (next_state == ST_DONE)
			done <= 1'b1;
	end

	// RULE8: one checker per lane, enabled together
	genvar g;
	generate
		for (g = 0; g < `LT_LANES; g = g + 1) begin : g_chk
			lane_checker u_chk (
				.clk(clk),
				.reset_n(reset_n),
				.rx_data(rx_data[g*32 +: 32]),
				.rx_is_k(rx_is_k[g*4 +: 4]),
				.check_en(check_en),
				.error(lane_error[g])
			);
		end
	endgenerate
endmodule

`default_nettype wire

//--- tb/lane_test_sequencer_monitor.sv
// Port checker for the lane test sequencer
`timescale 1ns/1ps
`default_nettype none
module lane_test_sequencer_monitor (
	input wire clk, reset_n, check_en, done,
	input wire [63:0] tx_data,
	input wire [7:0] tx_is_k,
	input wire [1:0] lane_error
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
property p_k; tx_is_k == 8'hff |-> tx_data == 64'hbcbcbcbcbcbcbcbc; endproperty
a_k: assert property (p_k) else $error("comma");
property p_fr; tx_is_k[3:0] == 4'h1 |-> ##7 tx_is_k[3:0] == 4'h8; endproperty
a_fr: assert property (p_fr) else $error("frame");
property p_cf; tx_is_k[3:0] == 4'h1 |=> tx_is_k == 8'h00 && tx_data == 64'hbcbcbcbcbcbcbcbc;
endproperty
a_cf: assert property (p_cf) else $error("filler");
property p_st; tx_is_k == 8'h11 |-> tx_data == 64'hbcbcbc1cbcbcbc1c; endproperty
a_st: assert property (p_st) else $error("start");
property p_en; $rose(check_en) |-> tx_is_k[3:0] == 4'h8; endproperty
a_en: assert property (p_en) else $error("enable");
property p_ec; $rose(lane_error[0]) |-> $past(check_en); endproperty
a_ec: assert property (p_ec) else $error("cause");
property p_sk; lane_error[0] |=> lane_error[0]; endproperty
a_sk: assert property (p_sk) else $error("sticky");
property p_dn; done |=> done && !check_en; endproperty
a_dn: assert property (p_dn) else $error("done");
c_en: cover property (check_en);
c_dn: cover property (done);
c_er: cover property (lane_error[0]);
endmodule
`default_nettype wire

//--- tb/lane_loop.sv
// Transceiver lanes looped back, with bit error injection
`timescale 1ns/1ps
`default_nettype none
module lane_loop (
	input wire clk, inject,
	input wire [63:0] tx_data,
	input wire [7:0] tx_is_k,
	output logic [63:0] rx_data,
	output logic [7:0] rx_is_k
);
always @(posedge clk) begin
	rx_data <= tx_data ^ {63'h0, inject};
	rx_is_k <= tx_is_k;
end
endmodule
`default_nettype wire

//--- tb/lane_test_sequencer_tb.sv
// Bench for the lane test sequencer
`timescale 1ns/1ps
`default_nettype none
module lane_test_sequencer_tb;
logic clk = 0, reset_n = 0, txd = 0, rxd = 0, inject = 0;
logic [63:0] tx_data, rx_data;
logic [7:0] tx_is_k, rx_is_k;
logic check_en, done, timed_out;
logic [1:0] lane_error, lb_lane_error;
logic lb_done;
int errors = 0, n_checks = 0, cyc = 0, n_k, n_fr, n_en;
always #5 clk = ~clk;
lane_test_sequencer #(.LOOPBACK(0), .RUN_CYCLES(16), .TIMEOUT_CYCLES(200)) DUT (
	.clk(clk), .reset_n(reset_n), .tx_reset_done(txd), .rx_reset_done(rxd),
	.tx_data(tx_data), .tx_is_k(tx_is_k), .rx_data_in(rx_data), .rx_is_k_in(rx_is_k),
	.check_en(check_en), .lane_error(lane_error), .done(done), .timed_out(timed_out));
lane_test_sequencer #(.LOOPBACK(1), .RUN_CYCLES(16), .TIMEOUT_CYCLES(200)) dut_loop (
	.clk(clk), .reset_n(reset_n), .tx_reset_done(txd), .rx_reset_done(rxd),
	.tx_data(), .tx_is_k(), .rx_data_in(rx_data), .rx_is_k_in(rx_is_k),
	.check_en(), .lane_error(lb_lane_error), .done(lb_done), .timed_out());
lane_loop lp (.clk(clk), .inject(inject), .tx_data(tx_data), .tx_is_k(tx_is_k),
	.rx_data(rx_data), .rx_is_k(rx_is_k));
always @(posedge clk) begin
	cyc++;
	n_k += (tx_is_k === 8'hff);
	n_fr += (tx_is_k === 8'h11);
	n_en += (check_en === 1'b1);
	if (cyc == 3000) begin
		errors++;
		end_of_test;
	end
end
task chk(input bit ok, input string m);
	n_checks++;
	if (!ok) begin
		errors++;
		$display("MISMATCH %0t %s", $time, m);
	end
endtask
task rst;
	@(posedge clk);
	reset_n <= 0;
	txd <= 0;
	rxd <= 0;
	inject <= 0;
	repeat (6) @(posedge clk);
	reset_n <= 1;
	n_k = 0;
	n_fr = 0;
	n_en = 0;
	@(posedge clk);
	txd <= 1;
endtask
task wd;
	for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk) #1;
endtask
task t_run;
	rst;
	rxd <= 1;
	wd;
	chk(n_k == 64, "commas");
	chk(n_fr == 4, "frames");
	chk(n_en == 16, "stream");
	chk(done === 1'b1 && timed_out === 1'b0, "end");
	chk(lane_error === 2'b00, "clean");
	chk(lb_done === 1'b1 && lb_lane_error === 2'b00, "loopback run");
	$display("t_run ended");
endtask
task t_err;
	rst;
	rxd <= 1;
	wait (check_en === 1'b1);
	@(posedge clk);
	inject <= 1;
	@(posedge clk);
	inject <= 0;
	wd;
	chk(lane_error === 2'b01, "flag");
	chk(lb_lane_error === 2'b00, "loopback isolated");
	rst;
	chk(lane_error === 2'b00, "clear");
	$display("t_err ended");
endtask
task t_tmo;
	rst;
	wd;
	chk(timed_out === 1'b1 && done === 1'b1, "timeout");
	chk(n_en == 0, "no check");
	$display("t_tmo ended");
endtask
task end_of_test;
	$display("checks %0d errors %0d", n_checks, errors);
	if (errors == 0 && n_checks > 0)
		$display("Simulation passed");
	else
		$display("Simulation failed");
	$finish;
endtask
initial begin
	t_run;
	t_err;
	t_tmo;
	end_of_test;
end
endmodule
bind lane_test_sequencer lane_test_sequencer_monitor mon (.*);
`default_nettype wire
